// ### core/kwi_unit.sv
/*
   Keypad wake-up interrupt unit: five active-low inputs latch one shared
   request, gated by a mask, cleared by acknowledge write or vector fetch.
   Assumes pins arrive asynchronously, an APB master on clk_sys, and a
   processor that pulses vector_fetch when it fetches this unit's vector.
*/
// Our own choices: the APB register port and the placing of the registers.
//
// How it works
// - Five inputs, each with its own enable
// - Enable bit forces input and pull-up on
// - Latch when enabled pins fall from all-high
// - Edge mode: no latch if another low
// - Level mode: holds until ack and all high
// - Vector fetch acknowledges the request
// - Ack write clears; ack reads zero
// - Falling edge after ack latches again
// - Unmasked pending request steers to FFD2/FFD3
// - Edge mode: ack clears immediately
// - Reset clears request and sensitivity bit
// - Pending flag ignores mask, reset clears
// - Enable overrides direction; read needs direction zero
// - Mask bit blocks request; reset clears
// - Sensitivity one: edges plus low levels
// - Status bits seven to four read zero
// - Enable bits gate inputs; reset clears
// - Active in wait, unmasked request wakes
// - Active in stop, unmasked request wakes
// - Break blocks ack unless break-clear enabled
`timescale 1ns/1ps
module kwi_unit
   import kwi_pkg::*;
#(
   parameter int NUM_INPUTS = kwi_pkg::KWI_NUM_INPUTS
)
(
   // Clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst_n,
   // APB slave
   input  wire kwi_pkg::kwi_apb_req_t  apb_req,
   output      kwi_pkg::kwi_apb_rsp_t  apb_rsp,
   // Keypad pins, active low, asynchronous
   input  wire logic [4:0]             keypad_input_pin,
   // Processor side
   input  wire logic                   vector_fetch,
   input  wire logic                   break_state,
   output      logic [15:0]            vector_address,
   // Pin control and interrupt
   output      kwi_pkg::kwi_pin_ctl_t  pin_ctl
);
   import kwi_pkg::*;

   // ------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------
   // The register layout is fixed at five enable bits
   if (NUM_INPUTS != KWI_NUM_INPUTS)
   begin : g_bad_width
      $error("kwi_unit supports exactly five inputs");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [4:0]   sync1;                             // First sync stage
      logic [4:0]   sync2;                             // Second sync stage
      logic [4:0]   prev;                              // Last gated sample
      logic [4:0]   input_enable_bits;                 // Enable register
      logic         sensitivity_select;                // Edge/level mode
      logic         request_mask;                      // Mask bit
      logic         break_clear_enable;                // Ack allowed in break
      logic         latch;                             // Shared request latch
      logic         acked;                             // Ack seen in level mode
      kwi_apb_rsp_t rsp;                               // Bus answer
      kwi_pin_ctl_t ctl;                               // Registered pin outputs
      logic [15:0]  vec;                               // Vector to processor
   } kwi_state_t;

   kwi_state_t st;                                     // Registered state
   kwi_state_t next_st;                                // Next state

   // Decoded bus strobes; writes take effect in the access phase
   logic       wr_access;
   logic       rd_setup;
   logic [4:0] low_enabled;                            // Enabled pins now low
   logic       any_low;                                // Any enabled pin low
   logic       fall;                                   // New falling activity
   logic       ack;                                    // Effective acknowledge

   // ------------------------------------------------------------
   // Combinational next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      // Two-stage synchroniser; only sync2 feeds logic
      next_st.sync1 = keypad_input_pin;
      next_st.sync2 = st.sync1;

      wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;
      rd_setup  = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

      // Disabled pins look high, so they neither trigger nor hold
      low_enabled = ~st.sync2 & st.input_enable_bits;
      any_low     = |low_enabled;
      // In edge mode, latch only when pins go low after all were high
      fall = any_low && ((st.prev | ~st.input_enable_bits) == KWI_ALL_HIGH);
      // In edge mode an already-low pin hides others' edges; prev tracks it
      next_st.prev = st.sync2 | ~st.input_enable_bits;

      // Ack from software write or vector fetch, gated in break
      ack = (vector_fetch
             || (wr_access && apb_req.paddr == KWI_OFF_STATUS_CONTROL
                 && apb_req.pwdata[KWI_BIT_ACK]))
            && (!break_state || st.break_clear_enable);

      // Request latch; a new edge wins over an acknowledge
      if (st.sensitivity_select)
      begin
         // Level mode: clears once ack and all-high both seen
         if (fall)
         begin
            next_st.latch = 1'b1;
            next_st.acked = 1'b0;
         end
         else if (st.latch)
         begin
            next_st.acked = st.acked || ack;
            if ((st.acked || ack) && !any_low)
            begin
               next_st.latch = 1'b0;
               next_st.acked = 1'b0;
            end
         end
         else if (any_low)
         begin
            next_st.latch = 1'b1;
         end
      end
      else
      begin
         // Edge mode: ack clears at once regardless of levels
         next_st.acked = 1'b0;
         if (fall)
         begin
            next_st.latch = 1'b1;
         end
         else if (ack)
         begin
            next_st.latch = 1'b0;
         end
      end

      // Register writes
      if (wr_access)
      begin
         if (apb_req.paddr == KWI_OFF_STATUS_CONTROL)
         begin
            next_st.sensitivity_select = apb_req.pwdata[KWI_BIT_SENSITIVITY];
            next_st.request_mask       = apb_req.pwdata[KWI_BIT_MASK];
         end
         else if (apb_req.paddr == KWI_OFF_INPUT_ENABLE)
         begin
            next_st.input_enable_bits = apb_req.pwdata[4:0];
         end
         else if (apb_req.paddr == KWI_OFF_BREAK_CONTROL)
         begin
            next_st.break_clear_enable = apb_req.pwdata[KWI_BIT_BRK_CLEAR];
         end
      end

      // Bus answer: zero wait states, unmapped reads zero with error
      next_st.rsp.pready  = apb_req.psel && !apb_req.penable;
      next_st.rsp.pslverr = 1'b0;
      next_st.rsp.prdata  = KWI_ZERO_WORD;
      if (apb_req.psel && !apb_req.penable)
      begin
         if (apb_req.paddr == KWI_OFF_STATUS_CONTROL)
         begin
            // Ack reads zero; upper bits zero
            next_st.rsp.prdata[KWI_BIT_SENSITIVITY] = st.sensitivity_select;
            next_st.rsp.prdata[KWI_BIT_MASK]        = st.request_mask;
            next_st.rsp.prdata[KWI_BIT_PENDING]     = st.latch;
         end
         else if (apb_req.paddr == KWI_OFF_INPUT_ENABLE)
         begin
            next_st.rsp.prdata[4:0] = st.input_enable_bits;
         end
         else if (apb_req.paddr == KWI_OFF_BREAK_CONTROL)
         begin
            next_st.rsp.prdata[KWI_BIT_BRK_CLEAR] = st.break_clear_enable;
         end
         else if (apb_req.paddr == KWI_OFF_VECTOR_ADDR)
         begin
            next_st.rsp.prdata[15:0] = KWI_VECTOR_HIGH;
         end
         else
         begin
            next_st.rsp.pslverr = rd_setup || apb_req.pwrite;
         end
      end

      // Outputs to processor and port
      next_st.ctl.irq         = next_st.latch && !next_st.request_mask;
      next_st.ctl.wake        = next_st.ctl.irq;
      next_st.ctl.pullup_en   = next_st.input_enable_bits;
      next_st.ctl.force_input = next_st.input_enable_bits;
      next_st.vec             = next_st.ctl.irq ? KWI_VECTOR_HIGH : 16'h0000;
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // Reset clears request, mode, mask and enables
         st <= '0;
         st.sync1 <= KWI_ALL_HIGH;
         st.sync2 <= KWI_ALL_HIGH;
         st.prev  <= KWI_ALL_HIGH;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign apb_rsp        = st.rsp;
   assign pin_ctl        = st.ctl;
   assign vector_address = st.vec;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_irq_gating : assert property (@(posedge clk_sys) disable iff (!rst_n)
      pin_ctl.irq == (st.latch && !st.request_mask))
      else $error("irq does not follow latch and mask");

   a_edge_ack_clr : assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!st.sensitivity_select && ack && !fall && !wr_access) |=> !st.latch)
      else $error("edge-mode ack did not clear request");

   a_level_hold : assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st.sensitivity_select && st.latch && any_low && !wr_access) |=> st.latch)
      else $error("level-mode request dropped while pin low");

   a_fall_latch : assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fall && !wr_access) |=> st.latch)
      else $error("falling edge did not latch request");

   a_pullup_en : assert property (@(posedge clk_sys) disable iff (!rst_n)
      pin_ctl.pullup_en == st.input_enable_bits)
      else $error("pull-up not tied to enable");

   a_break_block : assert property (@(posedge clk_sys) disable iff (!rst_n)
      (break_state && !st.break_clear_enable) |-> !ack)
      else $error("ack acted during protected break");

   a_vector_out : assert property (@(posedge clk_sys) disable iff (!rst_n)
      pin_ctl.irq |-> vector_address == KWI_VECTOR_HIGH)
      else $error("vector not presented");

   a_apb_ready : assert property (@(posedge clk_sys) disable iff (!rst_n)
      (apb_req.psel && !apb_req.penable) |=> apb_rsp.pready)
      else $error("apb answer late");

endmodule

// ### shared/kwi_pkg.sv
/*
   Package for the keypad wake-up interrupt unit: register offsets,
   field positions, reset values and the bus carrier structs.
   Assumes an APB master with 32-bit data and byte addresses.
*/
package kwi_pkg;

   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int KWI_NUM_INPUTS = 5;                 // Keypad inputs
   localparam int KWI_ADDR_W     = 12;                // APB address width

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] KWI_OFF_STATUS_CONTROL = 12'h000; // Status/control
   localparam logic [11:0] KWI_OFF_INPUT_ENABLE   = 12'h004; // Enable bits
   localparam logic [11:0] KWI_OFF_BREAK_CONTROL  = 12'h008; // Break-clear enable
   localparam logic [11:0] KWI_OFF_VECTOR_ADDR    = 12'h00C; // Vector location

   // ------------------------------------------------------------
   // Status/control field positions
   // ------------------------------------------------------------
   localparam int KWI_BIT_SENSITIVITY = 0;            // 1 = edge plus level
   localparam int KWI_BIT_MASK        = 1;            // 1 = request masked
   localparam int KWI_BIT_ACK         = 2;            // Write-only acknowledge
   localparam int KWI_BIT_PENDING     = 3;            // Read-only pending flag
   localparam int KWI_BIT_BRK_CLEAR   = 0;            // Break-clear enable

   // ------------------------------------------------------------
   // Constants
   // ------------------------------------------------------------
   localparam logic [31:0] KWI_ZERO_WORD   = 32'h0000_0000;
   localparam logic [15:0] KWI_VECTOR_HIGH = 16'hFFD2;  // Vector high byte address
   localparam logic [15:0] KWI_VECTOR_LOW  = 16'hFFD3;  // Vector low byte address
   localparam logic [4:0]  KWI_ENABLE_RST  = 5'h00;
   localparam logic [4:0]  KWI_ALL_HIGH    = 5'h1F;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } kwi_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } kwi_apb_rsp_t;

   typedef struct packed {
      logic       irq;                                // Request to processor
      logic       wake;                               // Wake from wait/stop
      logic [4:0] pullup_en;                          // Pull-up per pin
      logic [4:0] force_input;                        // Direction override
   } kwi_pin_ctl_t;

endpackage

// ### sim/kwi_keypad.sv
/*
   Keypad switch model for the keypad wake-up unit bench.
   Assumes the unit's per-pin pull-up enables arrive on clk_sys.
*/
`timescale 1ns/1ps
module kwi_keypad
(
   // Clock
   input  wire logic       clk_sys,
   // Keys held down and pull-ups
   input  wire logic [4:0] press,
   input  wire logic [4:0] pullup_en,
   // Pin levels seen by the unit
   output      logic [4:0] keypad_input_pin
);
   logic toggle = 1'b0;  // Floating-line pattern

   // ---------------------------------------------
   // Pin levels
   // ---------------------------------------------
   // A loose pin with no pull-up wanders, so it toggles each cycle
   always_ff @(posedge clk_sys)
      toggle <= ~toggle;

   // Pressed keys pull low; a pulled-up open key reads high
   always_comb
      for (int i = 0; i < 5; i++)
         keypad_input_pin[i] = press[i] ? 1'b0 : (pullup_en[i] | (toggle ^ i[0]));
endmodule

// ### sim/testbench.sv
/*
   Self-checking bench for the keypad wake-up unit.
   Assumes kwi_unit, kwi_pkg and the kwi_keypad switch model.
*/
`timescale 1ns/1ps
module testbench;
   import kwi_pkg::*;
   // ---------------------------------------------
   // Signals
   // ---------------------------------------------
   typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} kwi_row_t;
   logic         clk_sys = 1'b0;   // 50 ns clock
   logic         rst_n   = 1'b0;   // Async reset
   kwi_apb_req_t req     = '0;     // APB request
   kwi_apb_rsp_t rsp;              // APB response
   logic [4:0]   pins;             // Pin levels
   logic [4:0]   press   = 5'h00;  // Keys held
   logic         vfetch  = 1'b0;   // Vector fetch pulse
   logic         brk     = 1'b0;   // Debug break
   logic [15:0]  vaddr;            // Vector address
   kwi_pin_ctl_t ctl;              // Irq and pin control
   logic [31:0]  rd;               // Last read data
   logic         err;              // Last error flag
   int           n_mismatch = 0;
   int           num_checks = 0;
   int           cycles     = 0;
   // Ordinary register accesses: write flag, address, data, read, error
   kwi_row_t rows [9] = '{
      '{1'b1, 12'h000, 32'h0000_00F3, 32'h0000_0000, 1'b0},
      '{1'b0, 12'h000, 32'h0000_0000, 32'h0000_0003, 1'b0},
      '{1'b1, 12'h004, 32'h0000_001F, 32'h0000_0000, 1'b0},
      '{1'b0, 12'h004, 32'h0000_0000, 32'h0000_001F, 1'b0},
      '{1'b1, 12'h008, 32'h0000_0001, 32'h0000_0000, 1'b0},
      '{1'b0, 12'h008, 32'h0000_0000, 32'h0000_0001, 1'b0},
      '{1'b0, 12'h00C, 32'h0000_0000, 32'h0000_FFD2, 1'b0},
      '{1'b0, 12'h010, 32'h0000_0000, 32'h0000_0000, 1'b1},
      '{1'b1, 12'h010, 32'h0000_0005, 32'h0000_0000, 1'b1}};

   always #25 clk_sys = ~clk_sys;

   kwi_unit kwi_unit_i (.clk_sys(clk_sys), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
      .keypad_input_pin(pins), .vector_fetch(vfetch), .break_state(brk),
      .vector_address(vaddr), .pin_ctl(ctl));
   kwi_keypad kwi_keypad_i (.clk_sys(clk_sys), .press(press), .pullup_en(ctl.pullup_en),
      .keypad_input_pin(pins));

   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
         n_mismatch++;
      end
   endtask

   // One APB transfer; the answer is taken at the rising edge that sees pready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      logic rdy;
      int   t;
      t = 0;
      @(posedge clk_sys);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_sys);
      req.penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         rdy = rsp.pready;
         rd  = rsp.prdata;
         err = rsp.pslverr;
         t++;
      end while (rdy !== 1'b1 && t < 20);
      chk({31'h0, rdy}, 32'h0000_0001);
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask

   // Bounded wait for the request line
   task wait_irq(input logic exp);
      int t;
      t = 0;
      while (ctl.irq !== exp && t < 10)
      begin
         @(negedge clk_sys);
         t++;
      end
      chk({31'h0, ctl.irq}, {31'h0, exp});
   endtask

   // Line must stay put past the three-cycle latch delay
   task hold_chk(input logic exp);
      repeat (6) @(negedge clk_sys);
      chk({31'h0, ctl.irq}, {31'h0, exp});
   endtask

   // Keys change after the synchronisers settled the previous level
   task keys(input logic [4:0] k);
      repeat (4) @(posedge clk_sys);
      press <= k;
   endtask

   task fetch;
      @(posedge clk_sys);
      vfetch <= 1'b1;
      @(posedge clk_sys);
      vfetch <= 1'b0;
   endtask

   // Mask, enable, settle, acknowledge, unmask
   task setup(input logic [4:0] en, input logic mode);
      apb(1'b1, KWI_OFF_STATUS_CONTROL, {30'h0, 1'b1, mode});
      apb(1'b1, KWI_OFF_INPUT_ENABLE, {27'h0, en});
      repeat (4) @(posedge clk_sys);
      apb(1'b1, KWI_OFF_STATUS_CONTROL, {29'h0, 2'b11, mode});
      apb(1'b1, KWI_OFF_STATUS_CONTROL, {31'h0, mode});
   endtask

   task complete_run;
      $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ---------------------------------------------
   // Hang guard, far above the few hundred cycles needed
   // ---------------------------------------------
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_mismatch++;
         complete_run();
      end
   end

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial
   begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd_chk(KWI_OFF_STATUS_CONTROL, 32'h0000_0000);
      rd_chk(KWI_OFF_INPUT_ENABLE, 32'h0000_0000);
      chk({20'h0_0000, ctl}, 32'h0000_0000);
      foreach (rows[i])
      begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w)
            chk(rd, rows[i].q);
         chk({31'h0, err}, {31'h0, rows[i].e});
      end
      chk({22'h0, ctl.pullup_en, ctl.force_input}, 32'h0000_03FF);
      // Edge mode: latch, mask, acknowledge with the key still down
      setup(5'h1F, 1'b0);
      keys(5'h01);
      wait_irq(1'b1);
      chk({16'h0, vaddr}, {16'h0, KWI_VECTOR_HIGH});
      chk({31'h0, ctl.wake}, 32'h0000_0001);
      apb(1'b1, KWI_OFF_STATUS_CONTROL, 32'h0000_0002);
      wait_irq(1'b0);
      rd_chk(KWI_OFF_STATUS_CONTROL, 32'h0000_000A);
      apb(1'b1, KWI_OFF_STATUS_CONTROL, 32'h0000_0006);
      rd_chk(KWI_OFF_STATUS_CONTROL, 32'h0000_0002);
      apb(1'b1, KWI_OFF_STATUS_CONTROL, 32'h0000_0000);
      keys(5'h03);
      hold_chk(1'b0);
      apb(1'b1, KWI_OFF_INPUT_ENABLE, 32'h0000_001E);
      keys(5'h01);
      keys(5'h03);
      wait_irq(1'b1);
      fetch();
      wait_irq(1'b0);
      keys(5'h00);
      // Level mode: held until acknowledged and all keys up
      setup(5'h1F, 1'b1);
      keys(5'h04);
      wait_irq(1'b1);
      apb(1'b1, KWI_OFF_STATUS_CONTROL, 32'h0000_0005);
      hold_chk(1'b1);
      keys(5'h00);
      wait_irq(1'b0);
      keys(5'h08);
      wait_irq(1'b1);
      // Reset in mid-run with a key still down
      @(posedge clk_sys);
      rst_n <= 1'b0;
      @(negedge clk_sys);
      chk({31'h0, ctl.irq}, 32'h0000_0000);
      @(posedge clk_sys);
      rst_n <= 1'b1;
      rd_chk(KWI_OFF_STATUS_CONTROL, 32'h0000_0000);
      // Break: acknowledge blocked until break-clear enabled
      setup(5'h01, 1'b0);
      keys(5'h09);
      wait_irq(1'b1);
      @(posedge clk_sys);
      brk <= 1'b1;
      apb(1'b1, KWI_OFF_STATUS_CONTROL, 32'h0000_0004);
      hold_chk(1'b1);
      apb(1'b1, KWI_OFF_BREAK_CONTROL, 32'h0000_0001);
      apb(1'b1, KWI_OFF_STATUS_CONTROL, 32'h0000_0004);
      wait_irq(1'b0);
      @(posedge clk_sys);
      brk <= 1'b0;
      hold_chk(1'b0);
      complete_run();
   end
endmodule
